//--- src/pin_mux_defs.vh
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH

// register byte offsets
`define OFS_SEL_UPPER 12'h000
`define OFS_SEL_LOWER 12'h004
`define OFS_DIR 12'h008
`define OFS_DATA 12'h00C
`define OFS_PIN_STATE 12'h010

// register indices after decode
`define IDX_SEL_UPPER 3'h0
`define IDX_SEL_LOWER 3'h1
`define IDX_DIR 3'h2
`define IDX_DATA 3'h3
`define IDX_PIN_STATE 3'h4
`define IDX_NONE 3'h7

// writable bits, everything else reads as zero
`define SEL_UPPER_MASK 16'h015F
`define SEL_LOWER_MASK 16'hFD75
`define PIN_MASK 13'h1FFF
`define SEL_RESET 16'h0000
`define DIR_RESET 13'h0000
`define DATA_RESET 13'h0000

// upper select field positions
`define P12_BIT 8
`define P11_BIT 6
`define P10_BIT 4
`define P9_HI 3
`define P9_LO 2
`define P8_HI 1
`define P8_LO 0
// lower select field positions
`define P7_HI 15
`define P7_LO 14
`define P6_HI 13
`define P6_LO 12
`define P5_HI 11
`define P5_LO 10
`define P4_BIT 8
`define P3_BIT 6
`define P2_HI 5
`define P2_LO 4
`define P1_BIT 2
`define P0_BIT 0

// bits set at boot in expansion mode with rom disabled
`define SEL_UPPER_BOOT 16'h0150

// two-bit mode codes
`define MODE_PORT 2'h0
`define MODE_F1 2'h1
`define MODE_F2 2'h2
`define MODE_F3 2'h3

// levels given to unselected peripheral inputs
`define IDLE_TIMER_CLK 1'b0
`define IDLE_IRQ 1'b1
`define IDLE_DREQ 1'b1
`define IDLE_RXD 1'b1
`define IDLE_SCK 1'b1

`endif

//--- src/apb_reg_port.v
`include "pin_mux_defs.vh"

module apb_reg_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  output wire pready,
  output reg pslverr,
  output wire setup,
  output wire wr_commit,
  output reg [2:0] reg_idx
);

  // address decode for the five words
  always @* begin
    case (paddr)
      `OFS_SEL_UPPER: reg_idx = `IDX_SEL_UPPER;
      `OFS_SEL_LOWER: reg_idx = `IDX_SEL_LOWER;
      `OFS_DIR: reg_idx = `IDX_DIR;
      `OFS_DATA: reg_idx = `IDX_DATA;
      `OFS_PIN_STATE: reg_idx = `IDX_PIN_STATE;
      default: reg_idx = `IDX_NONE;
    endcase
  end

  // zero wait states
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr_commit = psel & penable & pwrite & (reg_idx != `IDX_NONE);

  // error flag prepared in setup, shown in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= (reg_idx == `IDX_NONE);
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule // apb_reg_port

//--- src/pin_cell.v
module pin_cell (
  input wire pclk,
  input wire presetn,
  input wire func_en,
  input wire func_out,
  input wire func_oe,
  input wire port_dir,
  input wire port_data,
  output reg pin_out,
  output reg pin_oe
);

  // function output or plain port driver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (func_en) begin
      pin_out <= func_out;
      pin_oe <= func_oe;
    end else begin
      pin_out <= port_data;
      pin_oe <= port_dir;
    end
  end

endmodule // pin_cell

//--- src/pin_function_controller.v
// Notes on behaviour
// - pin 12 select bit chooses write strobe
// - pin 11 select bit chooses chip select 1
// - pin 10 select bit chooses chip select 0
// - pin 9 field: port, timer D, irq 3
// - pin 8 field: port, timer C, irq 2
// - pin 7 field: port, timer B, select 3
// - pin 6 field: port, timer A, select 2
// - pin 5: port, serial clock 1, dma_request_1, ext_interrupt_1
// - pin 4 select bit chooses serial 1 transmit
// - pin 3 select bit chooses serial 1 receive
// - pin 2: port, serial clock 0, dma_request_0, ext_interrupt_0
// - pin 1 select bit chooses serial 0 transmit
// - pin 0 select bit chooses serial 0 receive
// - selects reset to port, boot strap exception
// - port pins follow the direction register bit
// - unused lower select bits read as zero
//
// Chosen here: the APB slave port and the register addresses.
`include "pin_mux_defs.vh"

module pin_function_controller (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rom_off_expansion_boot,
  input wire [12:0] pin_in,
  output wire [12:0] pin_out,
  output wire [12:0] pin_oe,
  input wire low_byte_write_strobe,
  input wire chip_select_0,
  input wire chip_select_1,
  input wire chip_select_2,
  input wire chip_select_3,
  input wire serial0_transmit,
  input wire serial1_transmit,
  input wire serial0_clock_out,
  input wire serial1_clock_out,
  output reg serial0_clock,
  output reg serial1_clock,
  output reg serial0_receive,
  output reg serial1_receive,
  output reg timer_ext_clock_a,
  output reg timer_ext_clock_b,
  output reg timer_ext_clock_c,
  output reg timer_ext_clock_d,
  output reg ext_interrupt_0,
  output reg ext_interrupt_1,
  output reg ext_interrupt_2,
  output reg ext_interrupt_3,
  output reg dma_request_0,
  output reg dma_request_1
);

  function is_code;
    input [1:0] field;
    input [1:0] code;
    begin
      is_code = (field == code);
    end
  endfunction

  reg [15:0] sel_upper_r;
  reg [15:0] sel_lower_r;
  reg [12:0] port_a_direction_low_r;
  reg [12:0] port_data_r;
  reg [12:0] pin_state_r;
  reg boot_pending_r;
  reg [12:0] func_en;
  reg [12:0] func_out;
  reg [12:0] func_oe;
  reg [31:0] read_value;
  wire setup;
  wire wr_commit;
  wire [2:0] reg_idx;
  wire [1:0] pin9_mode;
  wire [1:0] pin8_mode;
  wire [1:0] pin7_mode;
  wire [1:0] pin6_mode;
  wire [1:0] pin5_mode;
  wire [1:0] pin2_mode;
  wire pin12_select;
  wire pin11_select;
  wire pin10_select;
  wire pin4_select;
  wire pin3_select;
  wire pin1_select;
  wire pin0_select;

  // peripheral input routes
  wire route_timer_a;
  wire route_timer_b;
  wire route_timer_c;
  wire route_timer_d;
  wire route_irq_0;
  wire route_irq_1;
  wire route_irq_2;
  wire route_irq_3;
  wire route_dreq_0;
  wire route_dreq_1;
  wire route_sclk_0;
  wire route_sclk_1;
  wire route_rx_0;
  wire route_rx_1;

  apb_reg_port u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .setup(setup),
    .wr_commit(wr_commit),
    .reg_idx(reg_idx)
  );

  assign pin12_select = sel_upper_r[`P12_BIT];
  assign pin11_select = sel_upper_r[`P11_BIT];
  assign pin10_select = sel_upper_r[`P10_BIT];
  assign pin9_mode = {sel_upper_r[`P9_HI], sel_upper_r[`P9_LO]};
  assign pin8_mode = {sel_upper_r[`P8_HI], sel_upper_r[`P8_LO]};
  assign pin7_mode = {sel_lower_r[`P7_HI], sel_lower_r[`P7_LO]};
  assign pin6_mode = {sel_lower_r[`P6_HI], sel_lower_r[`P6_LO]};
  assign pin5_mode = {sel_lower_r[`P5_HI], sel_lower_r[`P5_LO]};
  assign pin4_select = sel_lower_r[`P4_BIT];
  assign pin3_select = sel_lower_r[`P3_BIT];
  assign pin2_mode = {sel_lower_r[`P2_HI], sel_lower_r[`P2_LO]};
  assign pin1_select = sel_lower_r[`P1_BIT];
  assign pin0_select = sel_lower_r[`P0_BIT];

  assign route_timer_d = is_code(pin9_mode, `MODE_F1);
  assign route_irq_3 = is_code(pin9_mode, `MODE_F2);
  assign route_timer_c = is_code(pin8_mode, `MODE_F1);
  assign route_irq_2 = is_code(pin8_mode, `MODE_F2);
  assign route_timer_b = is_code(pin7_mode, `MODE_F1);
  assign route_timer_a = is_code(pin6_mode, `MODE_F1);
  assign route_sclk_1 = is_code(pin5_mode, `MODE_F1);
  assign route_dreq_1 = is_code(pin5_mode, `MODE_F2);
  assign route_irq_1 = is_code(pin5_mode, `MODE_F3);
  assign route_rx_1 = pin3_select;
  assign route_sclk_0 = is_code(pin2_mode, `MODE_F1);
  assign route_dreq_0 = is_code(pin2_mode, `MODE_F2);
  assign route_irq_0 = is_code(pin2_mode, `MODE_F3);
  assign route_rx_0 = pin0_select;

  // select registers, with boot strap load
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_upper_r <= `SEL_RESET;
      sel_lower_r <= `SEL_RESET;
      boot_pending_r <= 1'b1;
    end else begin
      boot_pending_r <= 1'b0;
      if (wr_commit && reg_idx == `IDX_SEL_UPPER) begin
        sel_upper_r <= pwdata[15:0] & `SEL_UPPER_MASK;
      end else if (boot_pending_r && rom_off_expansion_boot) begin
        sel_upper_r <= sel_upper_r | `SEL_UPPER_BOOT;
      end
      if (wr_commit && reg_idx == `IDX_SEL_LOWER) begin
        sel_lower_r <= pwdata[15:0] & `SEL_LOWER_MASK;
      end
    end
  end

  // direction, data and pin sampling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_direction_low_r <= `DIR_RESET;
      port_data_r <= `DATA_RESET;
      pin_state_r <= `DATA_RESET;
    end else begin
      pin_state_r <= pin_in;
      if (wr_commit && reg_idx == `IDX_DIR) begin
        port_a_direction_low_r <= pwdata[12:0];
      end
      if (wr_commit && reg_idx == `IDX_DATA) begin
        port_data_r <= pwdata[12:0];
      end
    end
  end

  // read mux
  always @* begin
    read_value = 32'h0000_0000;
    case (reg_idx)
      `IDX_SEL_UPPER: read_value = {16'h0000, sel_upper_r};
      `IDX_SEL_LOWER: read_value = {16'h0000, sel_lower_r};
      `IDX_DIR: read_value = {19'h0_0000, port_a_direction_low_r};
      `IDX_DATA: read_value = {19'h0_0000, (port_a_direction_low_r & port_data_r) |
                             (~port_a_direction_low_r & pin_state_r)};
      `IDX_PIN_STATE: read_value = {19'h0_0000, pin_state_r};
      default: read_value = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= read_value;
    end
  end

  // pin output routing per mode
  always @* begin
    func_en = 13'h0000;
    func_out = 13'h0000;
    func_oe = 13'h0000;
    func_en[12] = pin12_select;
    func_out[12] = low_byte_write_strobe;
    func_oe[12] = 1'b1;
    func_en[11] = pin11_select;
    func_out[11] = chip_select_1;
    func_oe[11] = 1'b1;
    func_en[10] = pin10_select;
    func_out[10] = chip_select_0;
    func_oe[10] = 1'b1;
    func_en[9] = !is_code(pin9_mode, `MODE_PORT);
    func_en[8] = !is_code(pin8_mode, `MODE_PORT);
    // pin 7 timer in or select out
    func_en[7] = !is_code(pin7_mode, `MODE_PORT);
    func_out[7] = chip_select_3;
    func_oe[7] = is_code(pin7_mode, `MODE_F2);
    // pin 6 timer in or select out
    func_en[6] = !is_code(pin6_mode, `MODE_PORT);
    func_out[6] = chip_select_2;
    func_oe[6] = is_code(pin6_mode, `MODE_F2);
    // serial clock 1 uses direction bit
    func_en[5] = !is_code(pin5_mode, `MODE_PORT);
    func_out[5] = serial1_clock_out;
    func_oe[5] = is_code(pin5_mode, `MODE_F1) & port_a_direction_low_r[5];
    func_en[4] = pin4_select;
    func_out[4] = serial1_transmit;
    func_oe[4] = 1'b1;
    func_en[3] = pin3_select;
    // serial clock 0 uses direction bit
    func_en[2] = !is_code(pin2_mode, `MODE_PORT);
    func_out[2] = serial0_clock_out;
    func_oe[2] = is_code(pin2_mode, `MODE_F1) & port_a_direction_low_r[2];
    func_en[1] = pin1_select;
    func_out[1] = serial0_transmit;
    func_oe[1] = 1'b1;
    func_en[0] = pin0_select;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 13; gi = gi + 1) begin : g_pin
      pin_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .func_en(func_en[gi]),
        .func_out(func_out[gi]),
        .func_oe(func_oe[gi]),
        .port_dir(port_a_direction_low_r[gi]),
        .port_data(port_data_r[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi])
      );
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ext_clock_a <= `IDLE_TIMER_CLK;
      timer_ext_clock_b <= `IDLE_TIMER_CLK;
      timer_ext_clock_c <= `IDLE_TIMER_CLK;
      timer_ext_clock_d <= `IDLE_TIMER_CLK;
      ext_interrupt_0 <= `IDLE_IRQ;
      ext_interrupt_1 <= `IDLE_IRQ;
      ext_interrupt_2 <= `IDLE_IRQ;
      ext_interrupt_3 <= `IDLE_IRQ;
      dma_request_0 <= `IDLE_DREQ;
      dma_request_1 <= `IDLE_DREQ;
      serial0_receive <= `IDLE_RXD;
      serial1_receive <= `IDLE_RXD;
      serial0_clock <= `IDLE_SCK;
      serial1_clock <= `IDLE_SCK;
    end else begin
      timer_ext_clock_d <= route_timer_d ? pin_in[9] : `IDLE_TIMER_CLK;
      ext_interrupt_3 <= route_irq_3 ? pin_in[9] : `IDLE_IRQ;
      timer_ext_clock_c <= route_timer_c ? pin_in[8] : `IDLE_TIMER_CLK;
      ext_interrupt_2 <= route_irq_2 ? pin_in[8] : `IDLE_IRQ;
      timer_ext_clock_b <= route_timer_b ? pin_in[7] : `IDLE_TIMER_CLK;
      timer_ext_clock_a <= route_timer_a ? pin_in[6] : `IDLE_TIMER_CLK;
      // clock 1, dreq 1, irq 1
      serial1_clock <= route_sclk_1 ? pin_in[5] : `IDLE_SCK;
      dma_request_1 <= route_dreq_1 ? pin_in[5] : `IDLE_DREQ;
      ext_interrupt_1 <= route_irq_1 ? pin_in[5] : `IDLE_IRQ;
      serial1_receive <= route_rx_1 ? pin_in[3] : `IDLE_RXD;
      // clock 0, dreq 0, irq 0
      serial0_clock <= route_sclk_0 ? pin_in[2] : `IDLE_SCK;
      dma_request_0 <= route_dreq_0 ? pin_in[2] : `IDLE_DREQ;
      ext_interrupt_0 <= route_irq_0 ? pin_in[2] : `IDLE_IRQ;
      serial0_receive <= route_rx_0 ? pin_in[0] : `IDLE_RXD;
    end
  end

endmodule // pin_function_controller

//--- testbench/pfc_chk.sv
module function_select_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire rom_off_expansion_boot,
  input wire [12:0] pin_in,
  input wire [12:0] pin_out,
  input wire [12:0] pin_oe,
  input wire low_byte_write_strobe,
  input wire chip_select_1,
  input wire chip_select_3,
  input wire serial0_receive,
  input wire timer_ext_clock_d,
  input wire ext_interrupt_1,
  input wire ext_interrupt_3,
  input wire dma_request_0
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] su_r;
  logic [15:0] sl_r;
  logic boot_r;
  wire wr = psel && penable && pwrite;
  // shadow of both select registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      su_r <= 16'h0000;
      sl_r <= 16'h0000;
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
      if (boot_r && rom_off_expansion_boot) su_r <= 16'h0150;
      if (wr && paddr == 12'h000) su_r <= pwdata[15:0];
      if (wr && paddr == 12'h004) sl_r <= pwdata[15:0];
    end
  end
  AST_PIN12_STROBE: assert property ($past(su_r[8]) |->
    pin_oe[12] && pin_out[12] == $past(low_byte_write_strobe)) else $error("pin12 route");
  AST_PIN11_SELECT: assert property ($past(su_r[6]) |->
    pin_oe[11] && pin_out[11] == $past(chip_select_1)) else $error("pin11 route");
  AST_PIN9_TIMER: assert property (timer_ext_clock_d ==
    ($past(su_r[3:2]) == 2'b01 ? $past(pin_in[9]) : 1'b0)) else $error("pin9 timer");
  AST_PIN9_IRQ: assert property (ext_interrupt_3 ==
    ($past(su_r[3:2]) == 2'b10 ? $past(pin_in[9]) : 1'b1)) else $error("pin9 irq");
  AST_PIN7_SELECT: assert property ($past(sl_r[15:14]) == 2'b10 |->
    pin_oe[7] && pin_out[7] == $past(chip_select_3)) else $error("pin7 route");
  AST_PIN5_IRQ: assert property (ext_interrupt_1 ==
    ($past(sl_r[11:10]) == 2'b11 ? $past(pin_in[5]) : 1'b1)) else $error("pin5 irq");
  AST_PIN2_DREQ: assert property (dma_request_0 ==
    ($past(sl_r[5:4]) == 2'b10 ? $past(pin_in[2]) : 1'b1)) else $error("pin2 dreq");
  AST_PIN0_RX: assert property (serial0_receive ==
    ($past(sl_r[0]) ? $past(pin_in[0]) : 1'b1)) else $error("pin0 receive");
  AST_LOWER_RSVD: assert property (psel && penable && !pwrite && paddr == 12'h004 |->
    (prdata & 32'h0000_028A) == 32'h0000_0000) else $error("reserved bits set");
  cover property ($past(su_r[8]) && pin_oe[12]);
  cover property (psel && penable && pslverr);
  cover property ($past(sl_r[0]) && !serial0_receive);
  cover property ($past(sl_r[5:4]) == 2'b01 && pin_oe[2]);
endmodule // function_select_chk

//--- testbench/pin_side_model.sv
module pin_side_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [12:0] pin_out,
  input wire logic [12:0] pin_oe,
  input wire logic [12:0] ext_val,
  output logic [12:0] pin_in,
  output logic [8:0] per_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cnt_r;
  // wire level: device drive wins, else outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
  assign per_out = cnt_r;
  // peripheral outputs change every cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 9'h000;
    else cnt_r <= cnt_r + 9'h0A7;
  end
endmodule // pin_side_model

//--- testbench/tb_port_a_low_pin_function_select.sv
module tb_port_a_low_pin_function_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, rom_off_expansion_boot, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [12:0] ext_val;
  logic [2:0] v;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [12:0] pin_in, pin_out, pin_oe;
  wire [8:0] per;
  wire low_byte_write_strobe, chip_select_0, chip_select_1, chip_select_2, chip_select_3;
  wire serial0_transmit, serial1_transmit, serial0_clock_out, serial1_clock_out;
  wire serial0_clock, serial1_clock, serial0_receive, serial1_receive;
  wire timer_ext_clock_a, timer_ext_clock_b, timer_ext_clock_c, timer_ext_clock_d;
  wire ext_interrupt_0, ext_interrupt_1, ext_interrupt_2, ext_interrupt_3;
  wire dma_request_0, dma_request_1;
  int fail_count, compares;
  assign {low_byte_write_strobe, chip_select_0, chip_select_1, chip_select_2, chip_select_3,
    serial0_transmit, serial1_transmit, serial0_clock_out, serial1_clock_out} = per;
  pin_function_controller DUT (.*);
  pin_side_model partner (.pclk, .presetn, .pin_out, .pin_oe, .ext_val, .pin_in,
    .per_out(per));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_reset_vals();
    apb(1'b0, 12'h000, 32'h0);
    check(q, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0);
    check(q, 32'h0000_0000);
    check(timer_ext_clock_d, 1'b0);
  endtask
  task automatic t_port_mode();
    apb(1'b1, 12'h008, 32'h0000_1FFF);
    apb(1'b1, 12'h00C, 32'h0000_0AAA);
    @(negedge pclk);
    check(pin_oe, 13'h1FFF);
    check(pin_out, 13'h0AAA);
    @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0);
    check(q, 32'h0000_0AAA);
    apb(1'b1, 12'h008, 32'h0000_0000);
    @(negedge pclk);
    check(pin_oe, 13'h0000);
    @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0);
    check(q, 32'h0000_1555);
    apb(1'b0, 12'h010, 32'h0);
    check(q, 32'h0000_1555);
  endtask
  task automatic t_lower();
    // no forbidden code on pins 7 and 6
    apb(1'b1, 12'h004, 32'h0000_9FEF);
    ext_val <= 13'h0040;
    apb(1'b0, 12'h004, 32'h0);
    check(q, 32'h0000_9D65);
    @(negedge pclk);
    check(serial0_receive, 1'b0);
    check(serial1_receive, 1'b0);
    check(timer_ext_clock_a, 1'b1);
    check(timer_ext_clock_b, 1'b0);
    check(ext_interrupt_1, 1'b0);
    check(dma_request_1, 1'b1);
    check(dma_request_0, 1'b0);
    check(ext_interrupt_0, 1'b1);
    v = {serial0_transmit, chip_select_3, serial1_transmit};
    @(negedge pclk);
    check(pin_out[7], v[1]);
    check(pin_out[4], v[0]);
    check(pin_out[1], v[2]);
    check(pin_oe[7], 1'b1);
    @(posedge pclk);
  endtask
  task automatic t_upper();
    apb(1'b1, 12'h000, 32'h0000_8156);
    ext_val <= 13'h0200;
    apb(1'b0, 12'h000, 32'h0);
    check(q, 32'h0000_0156);
    @(negedge pclk);
    check(timer_ext_clock_d, 1'b1);
    check(ext_interrupt_3, 1'b1);
    check(ext_interrupt_2, 1'b0);
    v = {low_byte_write_strobe, chip_select_1, chip_select_0};
    @(negedge pclk);
    check(pin_out[12:10], v);
    check(pin_oe[12:10], 3'b111);
    @(posedge pclk);
  endtask
  task automatic t_clock();
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_4410);
    ext_val <= 13'h0180;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(timer_ext_clock_c, 1'b1);
    check(ext_interrupt_2, 1'b1);
    check(timer_ext_clock_b, 1'b1);
    check(serial1_clock, 1'b0);
    check(serial0_clock, 1'b0);
    @(posedge pclk);
    apb(1'b1, 12'h008, 32'h0000_0004);
    @(negedge pclk);
    check(pin_oe[5:2], 4'b0001);
    v = {2'b00, serial0_clock_out};
    @(negedge pclk);
    check(pin_out[2], v[0]);
    @(posedge pclk);
  endtask
  task automatic t_unmapped();
    apb(1'b0, 12'h020, 32'h0);
    check(e, 1'b1);
    check(q, 32'h0000_0000);
  endtask
  task automatic t_boot();
    rom_off_expansion_boot <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    check(q, 32'h0000_0150);
    apb(1'b0, 12'h004, 32'h0);
    check(q, 32'h0000_0000);
    check(pin_oe[12:10], 3'b111);
  endtask
  task automatic summarize();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #50us;
    fail_count++;
    summarize();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rom_off_expansion_boot = 1'b0;
    ext_val = 13'h1555;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset_vals();
    t_port_mode();
    t_lower();
    t_upper();
    t_clock();
    t_unmapped();
    t_boot();
    summarize();
  end
endmodule // tb_port_a_low_pin_function_select
bind pin_function_controller function_select_chk u_chk (.*);
